// [hdl/qrsp_controller.sv]
// controller end: beat phase, command issue, write data and read capture
`timescale 1ns/1ps
module qrsp_controller (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clkEn,
    qrsp_if.ctrl link,
    input wire logic singleClock,
    input wire logic stopReq,
    input wire logic rdReq,
    input wire logic [qrsp_pkg::ADDR_W-1:0] rdAddr,
    input wire logic wrReq,
    input wire logic [qrsp_pkg::ADDR_W-1:0] wrAddr,
    input wire logic [qrsp_pkg::BURST_W-1:0] wrData,
    input wire logic [qrsp_pkg::BURST_LANES-1:0] wrLanes_n,
    output logic rdReady,
    output logic wrReady,
    output logic [qrsp_pkg::BURST_W-1:0] rdData,
    output logic rdDone,
    output logic devClkEn
);

    qrsp_pkg::qrsp_stage_e rdStage;
    qrsp_pkg::qrsp_stage_e wrStage;
    qrsp_pkg::qrsp_stage_e next_wrStage;
    logic rdPend;
    logic wrPend;
    logic [qrsp_pkg::ADDR_W-1:0] rdPendAddr;
    logic [qrsp_pkg::ADDR_W-1:0] wrPendAddr;
    logic [qrsp_pkg::BURST_W-1:0] wrBuf;
    logic [qrsp_pkg::BURST_LANES-1:0] wrBufLanes_n;
    logic [1:0] capBeat;
    logic modeFixed;
    logic singleMode;
    logic run;
    logic issueRd;
    logic issueWr;
    logic [1:0] drvBeat;
    logic allIdle;

    // link logic only moves while the sram clock runs
    assign run = clkEn && devClkEn;

    // ========================================
    // issue decision, made one cycle ahead of the true beat
    always_comb begin
        issueRd = run && !link.kPhase && rdPend && !stopReq &&
            ((rdStage == qrsp_pkg::STG_IDLE) ||
            (rdStage == qrsp_pkg::STG_BEAT1) ||
            (rdStage == qrsp_pkg::STG_BEAT3));
        // read takes the beat, write waits for the next one
        issueWr = run && !link.kPhase && wrPend && !stopReq && !issueRd &&
            ((wrStage == qrsp_pkg::STG_IDLE) ||
            (wrStage == qrsp_pkg::STG_BEAT3));
        next_wrStage = qrsp_pkg::nextStage(wrStage,
            link.kPhase && !link.writeSel_n);
        drvBeat = qrsp_pkg::beatOf(next_wrStage);
        allIdle = (rdStage == qrsp_pkg::STG_IDLE) &&
            (wrStage == qrsp_pkg::STG_IDLE) && !link.busy;
    end

    // ========================================
    // beat phase and command pins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            link.kPhase <= 1'b1;
            link.readSel_n <= 1'b1;
            link.writeSel_n <= 1'b1;
            link.addr <= qrsp_pkg::ADDR_RESET;
        end else if (run) begin
            link.kPhase <= !link.kPhase;
            link.readSel_n <= !issueRd;
            link.writeSel_n <= !issueWr;
            if (issueRd) begin
                link.addr <= rdPendAddr;
            end else if (issueWr) begin
                link.addr <= wrPendAddr;
            end
        end
    end

    // mirrors of the sram burst stages
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdStage <= qrsp_pkg::STG_IDLE;
            wrStage <= qrsp_pkg::STG_IDLE;
        end else if (run) begin
            rdStage <= qrsp_pkg::nextStage(rdStage,
                link.kPhase && !link.readSel_n);
            wrStage <= next_wrStage;
        end
    end

    // ========================================
    // user requests; one of each kind held at a time
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdPend <= 1'b0;
            wrPend <= 1'b0;
            rdPendAddr <= qrsp_pkg::ADDR_RESET;
            wrPendAddr <= qrsp_pkg::ADDR_RESET;
            wrBuf <= '0;
            wrBufLanes_n <= '1;
            rdReady <= 1'b0;
            wrReady <= 1'b0;
        end else if (clkEn) begin
            if (rdReq && rdReady) begin
                rdPend <= 1'b1;
                rdPendAddr <= rdAddr;
            end else if (issueRd) begin
                rdPend <= 1'b0;
            end
            if (wrReq && wrReady) begin
                wrPend <= 1'b1;
                wrPendAddr <= wrAddr;
                wrBuf <= wrData;
                wrBufLanes_n <= wrLanes_n;
            end else if (issueWr) begin
                wrPend <= 1'b0;
            end
            // buffer is free again once its last word is on the pins
            rdReady <= !rdPend && !(rdReq && rdReady);
            wrReady <= !wrPend && !(wrReq && wrReady) &&
                (next_wrStage != qrsp_pkg::STG_LATCH) &&
                !(qrsp_pkg::isBeat(next_wrStage) &&
                (next_wrStage != qrsp_pkg::STG_BEAT3));
        end
    end

    // ========================================
    // write data, one word per beat, word 0 on the next true beat
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            link.dataIn <= qrsp_pkg::DATA_RESET;
            {link.lane3_enable_n, link.lane2_enable_n,
                link.lane1_enable_n, link.lane0_enable_n} <=
                qrsp_pkg::LANES_NONE;
        end else if (run) begin
            // lanes outside a burst write nothing
            if (qrsp_pkg::isBeat(next_wrStage)) begin
                link.dataIn <= wrBuf[drvBeat*qrsp_pkg::DATA_W +:
                    qrsp_pkg::DATA_W];
                {link.lane3_enable_n, link.lane2_enable_n,
                    link.lane1_enable_n, link.lane0_enable_n} <=
                    wrBufLanes_n[drvBeat*qrsp_pkg::LANES +:
                    qrsp_pkg::LANES];
            end else begin
                link.dataIn <= qrsp_pkg::DATA_RESET;
                {link.lane3_enable_n, link.lane2_enable_n,
                    link.lane1_enable_n, link.lane0_enable_n} <=
                    qrsp_pkg::LANES_NONE;
            end
        end
    end

    // ========================================
    // read capture, word 0 in the low bits
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            capBeat <= qrsp_pkg::BEAT_FIRST;
            rdData <= '0;
            rdDone <= 1'b0;
        end else if (clkEn) begin
            rdDone <= run && link.dataOutEn &&
                (capBeat == qrsp_pkg::BEAT_LAST);
            if (run && link.dataOutEn) begin
                rdData[capBeat*qrsp_pkg::DATA_W +: qrsp_pkg::DATA_W] <=
                    link.dataOut;
                capBeat <= 2'(capBeat + 2'h1);
            end
        end
    end

    // ========================================
    // clock stop only with both ports quiet; the mode strap is fixed
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            devClkEn <= 1'b1;
            modeFixed <= 1'b0;
            singleMode <= 1'b0;
            link.strobeTrue <= 1'b0;
            link.strobeComp <= 1'b0;
        end else if (clkEn) begin
            // stop waits for every burst to complete
            if (!stopReq) begin
                devClkEn <= 1'b1;
            end else if (allIdle && link.readSel_n && link.writeSel_n) begin
                devClkEn <= 1'b0;
            end
            if (!modeFixed) begin
                modeFixed <= 1'b1;
                singleMode <= singleClock;
            end
            // tied high from the first edge in single clock mode
            if (modeFixed ? singleMode : singleClock) begin
                link.strobeTrue <= 1'b1;
                link.strobeComp <= 1'b1;
            end else if (run) begin
                link.strobeTrue <= !link.kPhase;
                link.strobeComp <= link.kPhase;
            end
        end
    end

endmodule

// [hdl/qrsp_pkg.sv]
// shared constants, stage encoding and helpers for the burst sram port
package qrsp_pkg;

    // ========================================
    // organisation
    localparam int ADDR_W = 19;
    localparam int DATA_W = 36;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int BURST_LEN = 4;
    localparam int MEM_DEPTH = 1 << ADDR_W;
    localparam int BURST_W = BURST_LEN * DATA_W;
    localparam int BURST_LANES = BURST_LEN * LANES;

    // ========================================
    // values after reset
    localparam logic [DATA_W-1:0] DATA_RESET = 36'h0_0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 19'h0_0000;
    localparam logic [LANES-1:0] LANES_NONE = 4'hF;
    localparam logic [1:0] BEAT_FIRST = 2'h0;
    localparam logic [1:0] BEAT_LAST = 2'h3;

    // ========================================
    // burst stage of one port; K beats fall on even cycles of a command
    typedef enum logic [2:0] {
        STG_IDLE = 3'b000,
        STG_LATCH = 3'b001,
        STG_BEAT0 = 3'b010,
        STG_BEAT1 = 3'b011,
        STG_BEAT2 = 3'b100,
        STG_BEAT3 = 3'b101
    } qrsp_stage_e;

    // 2-bit linear wrap inside the aligned group of four
    function automatic logic [ADDR_W-1:0] burstAddr(
        input logic [ADDR_W-1:0] base,
        input logic [1:0] beat
    );
        return {base[ADDR_W-1:2], 2'(base[1:0] + beat)};
    endfunction

    function automatic logic [1:0] beatOf(input qrsp_stage_e s);
        case (s)
            STG_BEAT1: return 2'h1;
            STG_BEAT2: return 2'h2;
            STG_BEAT3: return 2'h3;
            default: return 2'h0;
        endcase
    endfunction

    function automatic qrsp_stage_e nextStage(
        input qrsp_stage_e s,
        input logic accept
    );
        if (accept) begin
            return STG_LATCH;
        end
        case (s)
            STG_LATCH: return STG_BEAT0;
            STG_BEAT0: return STG_BEAT1;
            STG_BEAT1: return STG_BEAT2;
            STG_BEAT2: return STG_BEAT3;
            default: return STG_IDLE;
        endcase
    endfunction

    function automatic logic isBeat(input qrsp_stage_e s);
        return (s == STG_BEAT0) || (s == STG_BEAT1) ||
            (s == STG_BEAT2) || (s == STG_BEAT3);
    endfunction

endpackage

// [hdl/qrsp_if.sv]
// link between the memory controller and the burst sram port
`timescale 1ns/1ps
interface qrsp_if;
    logic kPhase;
    logic readSel_n;
    logic writeSel_n;
    logic [qrsp_pkg::ADDR_W-1:0] addr;
    logic [qrsp_pkg::DATA_W-1:0] dataIn;
    logic lane0_enable_n;
    logic lane1_enable_n;
    logic lane2_enable_n;
    logic lane3_enable_n;
    logic strobeTrue;
    logic strobeComp;
    logic [qrsp_pkg::DATA_W-1:0] dataOut;
    logic dataOutEn;
    logic busy;

    modport dev (
        input kPhase,
        input readSel_n,
        input writeSel_n,
        input addr,
        input dataIn,
        input lane0_enable_n,
        input lane1_enable_n,
        input lane2_enable_n,
        input lane3_enable_n,
        input strobeTrue,
        input strobeComp,
        output dataOut,
        output dataOutEn,
        output busy
    );

    modport ctrl (
        output kPhase,
        output readSel_n,
        output writeSel_n,
        output addr,
        output dataIn,
        output lane0_enable_n,
        output lane1_enable_n,
        output lane2_enable_n,
        output lane3_enable_n,
        output strobeTrue,
        output strobeComp,
        input dataOut,
        input dataOutEn,
        input busy
    );
endinterface

// [hdl/qrsp_device.sv]
// sram end: read and write burst machines, byte lanes and storage array
`timescale 1ns/1ps

module qrsp_device (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clkEn,
    qrsp_if.dev link,
    output logic singleClockMode,
    output logic readActive,
    output logic writeActive
);

    // ========================================
    // storage; no reset, contents are undefined after power up
    logic [qrsp_pkg::DATA_W-1:0] mem [0:qrsp_pkg::MEM_DEPTH-1];

    qrsp_pkg::qrsp_stage_e rdStage;
    qrsp_pkg::qrsp_stage_e wrStage;
    qrsp_pkg::qrsp_stage_e next_rdStage;
    qrsp_pkg::qrsp_stage_e next_wrStage;
    logic [qrsp_pkg::ADDR_W-1:0] rdBase;
    logic [qrsp_pkg::ADDR_W-1:0] wrBase;
    logic [qrsp_pkg::ADDR_W-1:0] wrQueuedBase;
    logic wrQueued;
    logic next_wrQueued;
    logic modeCaught;
    logic rdAccept;
    logic wrAccept;
    logic rdLoad;
    logic [1:0] rdLoadBeat;
    logic [qrsp_pkg::LANES-1:0] laneEnable_n;

    assign laneEnable_n = {link.lane3_enable_n, link.lane2_enable_n,
        link.lane1_enable_n, link.lane0_enable_n};

    // ========================================
    // command decode
    always_comb begin
        // busy port ignores commands until its burst is far enough
        rdAccept = link.kPhase && !link.readSel_n &&
            ((rdStage == qrsp_pkg::STG_IDLE) ||
            (rdStage == qrsp_pkg::STG_BEAT2));
        // write decoded apart from the read port state
        wrAccept = link.kPhase && link.readSel_n && !link.writeSel_n &&
            ((wrStage == qrsp_pkg::STG_IDLE) ||
            ((wrStage == qrsp_pkg::STG_BEAT2) && !wrQueued));
    end

    // ========================================
    // read machine
    always_comb begin
        // read machine advances on its own
        next_rdStage = qrsp_pkg::nextStage(rdStage, rdAccept);
        rdLoad = (rdStage == qrsp_pkg::STG_LATCH) ||
            (rdStage == qrsp_pkg::STG_BEAT0) ||
            (rdStage == qrsp_pkg::STG_BEAT1) ||
            (rdStage == qrsp_pkg::STG_BEAT2);
        if (rdStage == qrsp_pkg::STG_LATCH) begin
            rdLoadBeat = qrsp_pkg::BEAT_FIRST;
        end else begin
            rdLoadBeat = 2'(qrsp_pkg::beatOf(rdStage) + 2'h1);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdStage <= qrsp_pkg::STG_IDLE;
            rdBase <= qrsp_pkg::ADDR_RESET;
        end else if (clkEn) begin
            rdStage <= next_rdStage;
            if (rdAccept) begin
                rdBase <= link.addr;
            end
        end
    end

    // old base still feeds the last word of a burst that is being chained
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            link.dataOut <= qrsp_pkg::DATA_RESET;
            link.dataOutEn <= 1'b0;
        end else if (clkEn) begin
            // word 0 appears two cycles after the command beat
            if (rdLoad) begin
                link.dataOut <=
                    mem[qrsp_pkg::burstAddr(rdBase, rdLoadBeat)];
            end
            // drive released once no beat is loaded
            link.dataOutEn <= rdLoad;
        end
    end

    // ========================================
    // write machine; a command on the third beat is held until the
    // running burst has taken its last word
    always_comb begin
        next_wrStage = qrsp_pkg::nextStage(wrStage, wrAccept);
        next_wrQueued = wrQueued;
        if (wrAccept && (wrStage == qrsp_pkg::STG_BEAT2)) begin
            next_wrStage = qrsp_pkg::STG_BEAT3;
            next_wrQueued = 1'b1;
        end else if ((wrStage == qrsp_pkg::STG_BEAT3) && wrQueued) begin
            next_wrStage = qrsp_pkg::STG_BEAT0;
            next_wrQueued = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wrStage <= qrsp_pkg::STG_IDLE;
            wrQueued <= 1'b0;
            wrBase <= qrsp_pkg::ADDR_RESET;
            wrQueuedBase <= qrsp_pkg::ADDR_RESET;
        end else if (clkEn) begin
            wrStage <= next_wrStage;
            wrQueued <= next_wrQueued;
            if (wrAccept && (wrStage == qrsp_pkg::STG_BEAT2)) begin
                wrQueuedBase <= link.addr;
            end else if (wrAccept) begin
                wrBase <= link.addr;
            end else if ((wrStage == qrsp_pkg::STG_BEAT3) && wrQueued) begin
                wrBase <= wrQueuedBase;
            end
        end
    end

    // words taken on the four beats after the latch cycle
    always_ff @(posedge clk_sys) begin
        if (clkEn && qrsp_pkg::isBeat(wrStage)) begin
            for (int i = 0; i < qrsp_pkg::LANES; i++) begin
                if (!laneEnable_n[i]) begin
                    mem[qrsp_pkg::burstAddr(wrBase,
                        qrsp_pkg::beatOf(wrStage))]
                        [i*qrsp_pkg::LANE_W +: qrsp_pkg::LANE_W] <=
                        link.dataIn[i*qrsp_pkg::LANE_W +: qrsp_pkg::LANE_W];
                end
            end
        end
    end

    // ========================================
    // status
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            link.busy <= 1'b0;
            readActive <= 1'b0;
            writeActive <= 1'b0;
        end else if (clkEn) begin
            // busy tells the controller when stopping is safe
            link.busy <= (next_rdStage != qrsp_pkg::STG_IDLE) ||
                (next_wrStage != qrsp_pkg::STG_IDLE) || next_wrQueued;
            readActive <= next_rdStage != qrsp_pkg::STG_IDLE;
            writeActive <= next_wrStage != qrsp_pkg::STG_IDLE;
        end
    end

    // ========================================
    // clock mode strap, taken once on the first complementary beat so
    // the controller has had one edge to settle the strobes
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            modeCaught <= 1'b0;
            singleClockMode <= 1'b0;
        end else if (clkEn && !modeCaught && !link.kPhase) begin
            // both strobes high selects single clock
            modeCaught <= 1'b1;
            singleClockMode <= link.strobeTrue && link.strobeComp;
        end
    end

endmodule

// [bench/qrsp_chk.sv]
// link assertions for the burst sram port pair
`timescale 1ns/1ps
module qrsp_chk (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic kPhase,
    input wire logic readSel_n,
    input wire logic writeSel_n,
    input wire logic strobeTrue,
    input wire logic [qrsp_pkg::DATA_W-1:0] dataOut,
    input wire logic dataOutEn,
    input wire logic busy
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // ========================================
    // read data timing
    rd_launch_a: assert property (
        kPhase && !readSel_n |-> ##2 dataOutEn [*4])
        else $error("read data not driven for four beats");
    oe_release_a: assert property (
        (kPhase && !readSel_n) ##1 (!(kPhase && !readSel_n)) [*4]
        |=> ##1 !dataOutEn)
        else $error("output drive not released after burst");
    oe_cause_a: assert property (
        $rose(dataOutEn) |-> $past(readSel_n, 2) == 1'b0
            && $past(kPhase, 2))
        else $error("output drive without read command");

    // ========================================
    // selects, bursts and clock stop
    sel_phase_a: assert property (
        !readSel_n || !writeSel_n |-> kPhase)
        else $error("select issued off the true beat");
    wr_busy_a: assert property (
        kPhase && !writeSel_n |=> busy [*4])
        else $error("write burst not held busy");
    stop_idle_a: assert property (
        $fell(clkEn) |-> $past(busy) == 1'b0)
        else $error("clock stopped with burst pending");
    freeze_out_a: assert property (
        !clkEn |=> $stable(dataOutEn) && $stable(dataOut) && $stable(busy))
        else $error("outputs moved while clock stopped");
    strobe_hold_a: assert property (
        strobeTrue |=> strobeTrue)
        else $error("clock mode changed during operation");

    cover property (kPhase && !readSel_n);
    cover property (kPhase && !writeSel_n);
    cover property ($fell(clkEn));
endmodule

// [bench/testbench.sv]
// self-checking bench for the burst sram port pair
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic singleClock = 1'b1;
    logic stopReq = 1'b0;
    logic rdReq = 1'b0;
    logic wrReq = 1'b0;
    logic [18:0] rdAddr = 19'h0_0000;
    logic [18:0] wrAddr = 19'h0_0000;
    logic [143:0] wrData = '0;
    logic [15:0] wrLanes_n = 16'hFFFF;
    logic rdReady, wrReady, rdDone, devClkEn;
    logic [143:0] rdData;
    logic singleClockMode, readActive, writeActive;
    logic both = 1'b0;
    int err_total = 0;
    int total_checks = 0;
    logic [143:0] w = {36'h4_4444_4444, 36'h3_3333_3333,
        36'h2_2222_2222, 36'h1_1111_1111};
    logic [143:0] old, expd;

    always #10 clk_sys = ~clk_sys;

    // concurrent activity of both burst machines
    always @(posedge clk_sys) begin
        if (readActive && writeActive) begin
            both <= 1'b1;
        end
    end

    qrsp_if link();
    qrsp_device u_qrsp_device (.clk_sys(clk_sys), .rst_n(rst_n),
        .clkEn(devClkEn), .link(link.dev),
        .singleClockMode(singleClockMode), .readActive(readActive),
        .writeActive(writeActive));
    qrsp_controller u_qrsp_controller (.clk_sys(clk_sys), .rst_n(rst_n),
        .clkEn(1'b1), .link(link.ctrl), .singleClock(singleClock),
        .stopReq(stopReq), .rdReq(rdReq), .rdAddr(rdAddr), .wrReq(wrReq),
        .wrAddr(wrAddr), .wrData(wrData), .wrLanes_n(wrLanes_n),
        .rdReady(rdReady), .wrReady(wrReady), .rdData(rdData),
        .rdDone(rdDone), .devClkEn(devClkEn));
    qrsp_chk u_qrsp_chk (.clk_sys(clk_sys), .rst_n(rst_n),
        .clkEn(devClkEn), .kPhase(link.kPhase),
        .readSel_n(link.readSel_n), .writeSel_n(link.writeSel_n),
        .strobeTrue(link.strobeTrue), .dataOut(link.dataOut),
        .dataOutEn(link.dataOutEn), .busy(link.busy));

    // ========================================
    // helpers
    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic cmpBit(string what, logic exp, logic got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s exp %b got %b", what, exp, got);
        end
    endtask

    task automatic cmpBurst(string what, logic [143:0] exp,
        logic [143:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic wrBurst(logic [18:0] a, logic [143:0] d,
        logic [15:0] ln);
        for (int i = 0; i < 40 && !wrReady; i++) tick;
        cmpBit("wrReady", 1'b1, wrReady);
        wrAddr = a;
        wrData = d;
        wrLanes_n = ln;
        wrReq = 1'b1;
        tick;
        wrReq = 1'b0;
        for (int i = 0; i < 20 && !writeActive; i++) tick;
        cmpBit("wrStart", 1'b1, writeActive);
        for (int i = 0; i < 20 && writeActive; i++) tick;
        cmpBit("wrEnd", 1'b0, writeActive);
    endtask

    task automatic rdBurst(logic [18:0] a, logic [143:0] exp);
        for (int i = 0; i < 40 && !rdReady; i++) tick;
        cmpBit("rdReady", 1'b1, rdReady);
        rdAddr = a;
        rdReq = 1'b1;
        tick;
        rdReq = 1'b0;
        for (int i = 0; i < 40 && !rdDone; i++) tick;
        cmpBit("rdDone", 1'b1, rdDone);
        cmpBurst("rdData", exp, rdData);
        tick;
    endtask

    // ========================================
    // scenarios
    task automatic testWrap;
        wrBurst(19'h0_0012, w, 16'h0000);
        rdBurst(19'h0_0010, {w[71:0], w[143:72]});
        rdBurst(19'h0_0012, w);
    endtask

    task automatic testLanes;
        old = {w[71:0], w[143:72]};
        expd = old;
        // beat lanes: 0+1, none, 0 only, 1 only
        for (int k = 0; k < 4; k++) begin
            for (int j = 0; j < 4; j++) begin
                if (!(16'hDEFC >> (4 * k + j) & 1)) begin
                    expd[36 * k + 9 * j +: 9] = 9'h1FF;
                end
            end
        end
        wrBurst(19'h0_0010, {144{1'b1}}, 16'hDEFC);
        rdBurst(19'h0_0010, expd);
    endtask

    task automatic testDual;
        // wrapped read so stale data from the last read cannot match
        rdAddr = 19'h0_0012;
        wrAddr = 19'h0_0020;
        wrData = ~w;
        wrLanes_n = 16'h0000;
        rdReq = 1'b1;
        wrReq = 1'b1;
        tick;
        rdReq = 1'b0;
        wrReq = 1'b0;
        for (int i = 0; i < 40 && !rdDone; i++) tick;
        cmpBit("rdDoneDual", 1'b1, rdDone);
        cmpBurst("rdDual", {expd[71:0], expd[143:72]}, rdData);
        for (int i = 0; i < 20 && writeActive; i++) tick;
        cmpBit("overlap", 1'b1, both);
        rdBurst(19'h0_0020, ~w);
    endtask

    task automatic testStop;
        rdAddr = 19'h0_0010;
        rdReq = 1'b1;
        tick;
        rdReq = 1'b0;
        for (int i = 0; i < 6 && !readActive; i++) tick;
        cmpBit("rdIssued", 1'b1, readActive);
        stopReq = 1'b1;
        for (int i = 0; i < 40 && devClkEn; i++) tick;
        cmpBit("stopped", 1'b0, devClkEn);
        cmpBit("busyStop", 1'b0, link.busy);
        cmpBit("oeStop", 1'b0, link.dataOutEn);
        cmpBurst("rdStop", expd, rdData);
        repeat (4) tick;
        cmpBit("held", 1'b0, devClkEn);
        stopReq = 1'b0;
        repeat (2) tick;
        cmpBit("restart", 1'b1, devClkEn);
        rdBurst(19'h0_0020, ~w);
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ========================================
    // main sequence and watchdog
    initial begin
        repeat (8) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        repeat (4) tick;
        cmpBit("modeStrap", 1'b1, singleClockMode);
        cmpBit("strobeTrue", 1'b1, link.strobeTrue);
        testWrap;
        testLanes;
        testDual;
        testStop;
        test_done;
    end

    // runs take well under a thousand cycles
    initial begin
        #200000;
        err_total++;
        test_done;
    end
endmodule
